// ==== common/scg_pkg.sv ====
package scg_pkg;

  // Divider code is the power of two of the ratio.
  localparam int          DIV_W                = 3;
  localparam logic [2:0]  PWM_DIV_BY_ONE       = 3'h0;
  localparam logic [2:0]  PWM_DIV_BY_SIXTYFOUR = 3'h6;
  localparam logic [2:0]  PWM_DIV_RESET        = PWM_DIV_BY_ONE;
  localparam int          PWM_CNT_W            = 6;

  // Clocks between enabling a peripheral and it becoming usable.
  localparam int          ENABLE_DELAY_CYC     = 5;
  localparam int          DLY_W                = 3;
  localparam logic [2:0]  DLY_LOAD             = 3'(ENABLE_DELAY_CYC);

  // Reset values of the configuration bits.
  localparam logic        GATING_RESET         = 1'b0;

  typedef enum logic [0:0] {
    SCG_RUN   = 1'b0,
    SCG_SLEEP = 1'b1
  } scg_state_t;

  // Status read back by software.
  typedef struct packed {
    logic             in_sleep;
    logic             gating_en;
    logic [DIV_W-1:0] pwm_div;
  } scg_stat_t;

endpackage

// ==== rtl/scg_pwm_div.sv ====
`timescale 1ns/10ps
module scg_pwm_div
  import scg_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic [DIV_W-1:0] div_code,
  output logic                  tick
);

  logic [PWM_CNT_W-1:0] cnt_ff;
  logic [PWM_CNT_W-1:0] nxt_cnt;
  logic [PWM_CNT_W-1:0] limit;
  logic                 tick_ff;
  logic                 nxt_tick;

  ////////////////////////////////////////////////////////////////////////////
  // A tick every 2**div_code clocks; it holds when the PWM clock is gated.
  always_comb begin
    limit    = PWM_CNT_W'((7'h01 << div_code) - 7'h01);
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (en) begin
      if (cnt_ff >= limit) begin
        nxt_cnt  = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 6'h01;
      end
    end
  end

  // Count is cleared only by reset and at the end of a period, so a gated PWM resumes mid-period.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

  a_div_one_tick: assert property (@(posedge clk) disable iff (rst)
    (en && div_code == PWM_DIV_BY_ONE && $stable(div_code)) |=> tick)
    else $error("divide by one did not tick every clock");

  a_div_gap_tick: assert property (@(posedge clk) disable iff (rst)
    (tick && div_code != PWM_DIV_BY_ONE && $stable(div_code)) |=> !tick)
    else $error("divided PWM tick came on back to back clocks");

endmodule

// ==== rtl/scg_top.sv ====
`timescale 1ns/10ps
module scg_top
  import scg_pkg::*;
#(
  parameter int NUM_PERIPH = 32,
  parameter int PWM_IDX    = 20
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  sleep_req,
  input  wire logic                  run_en_wr,
  input  wire logic [NUM_PERIPH-1:0] run_en_data,
  input  wire logic                  sleep_en_wr,
  input  wire logic [NUM_PERIPH-1:0] sleep_en_data,
  input  wire logic                  gating_wr,
  input  wire logic                  gating_data,
  input  wire logic                  pwm_div_wr,
  input  wire logic [DIV_W-1:0]      pwm_div_data,
  input  wire logic [NUM_PERIPH-1:0] periph_access,
  input  wire logic [NUM_PERIPH-1:0] periph_wake,
  output logic      [NUM_PERIPH-1:0] run_en_q,
  output logic      [NUM_PERIPH-1:0] sleep_en_q,
  output logic      [NUM_PERIPH-1:0] periph_clk_en,
  output logic      [NUM_PERIPH-1:0] periph_ready,
  output logic      [NUM_PERIPH-1:0] bus_fault,
  output scg_stat_t                  status,
  output logic                       wake_req,
  output logic                       pwm_tick
);

  scg_state_t            state_ff;
  scg_state_t            nxt_state;
  logic [NUM_PERIPH-1:0] run_en_ff;
  logic [NUM_PERIPH-1:0] nxt_run_en;
  logic [NUM_PERIPH-1:0] sleep_en_ff;
  logic [NUM_PERIPH-1:0] nxt_sleep_en;
  logic                  gating_ff;
  logic                  nxt_gating;
  logic [DIV_W-1:0]      pwm_div_ff;
  logic [DIV_W-1:0]      nxt_pwm_div;
  logic [NUM_PERIPH-1:0] clk_en_ff;
  logic [NUM_PERIPH-1:0] nxt_clk_en;
  logic [NUM_PERIPH-1:0] ready_ff;
  logic [NUM_PERIPH-1:0] fault_ff;
  logic [NUM_PERIPH-1:0] nxt_fault;
  logic                  wake_ff;
  logic                  nxt_wake;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits written by software.
  always_comb begin
    nxt_run_en   = run_en_wr ? run_en_data : run_en_ff;
    nxt_sleep_en = sleep_en_wr ? sleep_en_data : sleep_en_ff;
    nxt_gating   = gating_wr ? gating_data : gating_ff;
    nxt_pwm_div  = pwm_div_ff;
    // An illegal divider code is dropped so the readback stays legal.
    if (pwm_div_wr && pwm_div_data <= PWM_DIV_BY_SIXTYFOUR) begin
      nxt_pwm_div = pwm_div_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_en_ff   <= '0;
      sleep_en_ff <= '0;
      gating_ff   <= GATING_RESET;
      pwm_div_ff  <= PWM_DIV_RESET;
    end else begin
      run_en_ff   <= nxt_run_en;
      sleep_en_ff <= nxt_sleep_en;
      gating_ff   <= nxt_gating;
      pwm_div_ff  <= nxt_pwm_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep tracking follows the processor's sleep level.
  always_comb begin
    case (state_ff)
      SCG_RUN: begin
        nxt_state = sleep_req ? SCG_SLEEP : SCG_RUN;
      end
      SCG_SLEEP: begin
        nxt_state = sleep_req ? SCG_SLEEP : SCG_RUN;
      end
      default: begin
        nxt_state = SCG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= SCG_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gate enables.  Gating never resets a peripheral, so its flops
  // simply hold their contents while the clock is stopped.
  always_comb begin
    nxt_clk_en = nxt_run_en;
    if (nxt_state == SCG_SLEEP && nxt_gating) begin
      nxt_clk_en = nxt_run_en & nxt_sleep_en;
    end
  end

  // Wake is only honoured from peripherals whose clock still runs.
  always_comb begin
    nxt_wake  = (state_ff == SCG_SLEEP) && |(periph_wake & clk_en_ff);
    nxt_fault = periph_access & ~ready_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_en_ff <= '0;
      wake_ff   <= 1'b0;
      fault_ff  <= '0;
    end else begin
      clk_en_ff <= nxt_clk_en;
      wake_ff   <= nxt_wake;
      fault_ff  <= nxt_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per peripheral settle counter, started when its run enable rises.
  for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_settle
    logic [DLY_W-1:0] cnt_ff;
    logic [DLY_W-1:0] nxt_cnt;
    logic             nxt_ready;

    always_comb begin
      nxt_cnt = cnt_ff;
      if (nxt_run_en[i] && !run_en_ff[i]) begin
        nxt_cnt = DLY_LOAD;
      end else if (cnt_ff != '0) begin
        nxt_cnt = cnt_ff - 3'h1;
      end
      nxt_ready = run_en_ff[i] && (cnt_ff == 3'h1 || (cnt_ff == '0
                  && ready_ff[i]));
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt_ff      <= '0;
        ready_ff[i] <= 1'b0;
      end else begin
        cnt_ff      <= nxt_cnt;
        ready_ff[i] <= nxt_ready && nxt_run_en[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM divider; its tick stops while the PWM clock itself is gated.
  scg_pwm_div u_pwm_div (
    .clk      (clk),
    .rst      (rst),
    .en       (clk_en_ff[PWM_IDX]),
    .div_code (pwm_div_ff),
    .tick     (pwm_tick)
  );

  // Outputs.
  assign run_en_q         = run_en_ff;
  assign sleep_en_q       = sleep_en_ff;
  assign periph_clk_en    = clk_en_ff;
  assign periph_ready     = ready_ff;
  assign bus_fault        = fault_ff;
  assign wake_req         = wake_ff;
  assign status           = '{in_sleep:  (state_ff == SCG_SLEEP),
                              gating_en: gating_ff,
                              pwm_div:   pwm_div_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_sleep_gate_off: assert property (@(posedge clk) disable iff (rst)
    (state_ff == SCG_SLEEP && gating_ff) |-> (clk_en_ff & ~sleep_en_ff) == '0)
    else $error("clock left running for a sleep-disabled peripheral");

  a_wake_restart: assert property (@(posedge clk) disable iff (rst)
    $fell(state_ff == SCG_SLEEP) |-> clk_en_ff == run_en_ff)
    else $error("clocks not restored on leaving sleep");

  a_gating_off_run: assert property (@(posedge clk) disable iff (rst)
    !gating_ff |-> clk_en_ff == run_en_ff)
    else $error("sleep enables acted while master gating was clear");

  a_sleep_en_keep: assert property (@(posedge clk) disable iff (rst)
    (clk_en_ff & sleep_en_ff) == (run_en_ff & sleep_en_ff))
    else $error("sleep-enabled peripheral lost its clock");

  a_wake_raise: assert property (@(posedge clk) disable iff (rst)
    (state_ff == SCG_SLEEP && |(periph_wake & clk_en_ff)) |=> wake_req)
    else $error("wake from clocked peripheral was not raised");

  a_div_legal: assert property (@(posedge clk) disable iff (rst)
    status.pwm_div <= PWM_DIV_BY_SIXTYFOUR)
    else $error("PWM divider readback holds an illegal code");

  a_settle_five: assert property (@(posedge clk) disable iff (rst)
    $rose(run_en_ff[0]) |-> !ready_ff[0] [*5] ##1
      (ready_ff[0] || !run_en_ff[0] || $past(run_en_ff[0], 5) == 1'b0
       && !run_en_ff[0]))
    else $error("peripheral ready time is not five clocks");

  a_early_fault: assert property (@(posedge clk) disable iff (rst)
    (periph_access[0] && !ready_ff[0]) |=> bus_fault[0])
    else $error("early access did not fault");

  a_late_no_fault: assert property (@(posedge clk) disable iff (rst)
    (periph_access[0] && ready_ff[0]) |=> !bus_fault[0])
    else $error("access to a ready peripheral faulted");

  a_pwm_gated_quiet: assert property (@(posedge clk) disable iff (rst)
    !clk_en_ff[PWM_IDX] |=> !pwm_tick)
    else $error("PWM tick ran while the PWM clock was gated");

  a_sleep_en_wr: assert property (@(posedge clk) disable iff (rst)
    sleep_en_wr |=> sleep_en_q == $past(sleep_en_data))
    else $error("sleep enable write not stored");

endmodule

// ==== test/tb_scg_top.sv ====
`timescale 1ns/10ps
module tb_scg_top;
  import scg_pkg::*;

  logic             clk;
  logic             rst;
  logic             sleep_req;
  logic             run_en_wr;
  logic [31:0]      run_en_data;
  logic             sleep_en_wr;
  logic [31:0]      sleep_en_data;
  logic             gating_wr;
  logic             gating_data;
  logic             pwm_div_wr;
  logic [DIV_W-1:0] pwm_div_data;
  logic [31:0]      periph_access;
  logic [31:0]      periph_wake;
  logic [31:0]      run_en_q;
  logic [31:0]      sleep_en_q;
  logic [31:0]      periph_clk_en;
  logic [31:0]      periph_ready;
  logic [31:0]      bus_fault;
  scg_stat_t        status;
  logic             wake_req;
  logic             pwm_tick;
  int               bad_count;
  int               cmp_count;
  int               cyc_cnt;

  scg_top #(.NUM_PERIPH(32), .PWM_IDX(20)) u_scg_top (
    .clk(clk), .rst(rst), .sleep_req(sleep_req),
    .run_en_wr(run_en_wr), .run_en_data(run_en_data),
    .sleep_en_wr(sleep_en_wr), .sleep_en_data(sleep_en_data),
    .gating_wr(gating_wr), .gating_data(gating_data),
    .pwm_div_wr(pwm_div_wr), .pwm_div_data(pwm_div_data),
    .periph_access(periph_access), .periph_wake(periph_wake),
    .run_en_q(run_en_q), .sleep_en_q(sleep_en_q),
    .periph_clk_en(periph_clk_en), .periph_ready(periph_ready),
    .bus_fault(bus_fault), .status(status), .wake_req(wake_req),
    .pwm_tick(pwm_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // A 5 ns clock, and a cycle ceiling so that a stuck wait cannot hang.
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Four-state compare, so an unknown output never counts as a match.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One configuration write: 0 run, 1 sleep, 2 gating, 3 divider.
  task automatic cfg(input int k, input logic [31:0] d);
    @(posedge clk);
    case (k)
      0: begin run_en_wr <= 1'b1; run_en_data <= d; end
      1: begin sleep_en_wr <= 1'b1; sleep_en_data <= d; end
      2: begin gating_wr <= 1'b1; gating_data <= d[0]; end
      default: begin pwm_div_wr <= 1'b1; pwm_div_data <= d[2:0]; end
    endcase
    @(posedge clk);
    run_en_wr   <= 1'b0;
    sleep_en_wr <= 1'b0;
    gating_wr   <= 1'b0;
    pwm_div_wr  <= 1'b0;
    #1;
  endtask

  // Wait n edges, then look once the edge's updates have landed.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic test_done();
    $display("counts: compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Enable latency: access too early faults, access after five clocks works.
  task automatic test_ready();
    cfg(0, 32'h0010_000f);
    chk("run_en_q", 32'h0010_000f, run_en_q);
    chk("clk_en", 32'h0010_000f, periph_clk_en);
    @(posedge clk);
    periph_access <= 32'h1;
    @(posedge clk);
    periph_access <= 32'h0;
    #1;
    chk("fault", 32'h1, bus_fault);
    wait_cyc(2);
    chk("ready_early", 32'h0, periph_ready);
    chk("fault_once", 32'h0, bus_fault);
    wait_cyc(1);
    chk("ready", 32'h0010_000f, periph_ready);
    @(posedge clk);
    periph_access <= 32'h1;
    @(posedge clk);
    periph_access <= 32'h0;
    #1;
    chk("fault_late", 32'h0, bus_fault);
    $display("test ready done");
  endtask

  // Period of the PWM time base for one divider code.
  task automatic pwm_case(input logic [2:0] c);
    int n;
    cfg(3, {29'h0, c});
    chk("pwm_div", {29'h0, c}, {29'h0, status.pwm_div});
    n = 0;
    while (pwm_tick !== 1'b1 && n < 200) begin
      wait_cyc(1);
      n++;
    end
    n = 0;
    do begin
      wait_cyc(1);
      n++;
    end while (pwm_tick !== 1'b1 && n < 200);
    chk("pwm_period", 32'h1 << c, n);
  endtask

  task automatic test_pwm();
    for (int c = 0; c < 7; c++)
      pwm_case(c[2:0]);
    cfg(3, 32'h7);
    chk("pwm_div_keep", 32'h6, {29'h0, status.pwm_div});
    $display("test pwm done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sleep with and without master gating; wake from a clocked peripheral.
  task automatic test_sleep();
    cfg(1, 32'h5);
    chk("sleep_en_q", 32'h5, sleep_en_q);
    chk("clk_en_run", 32'h0010_000f, periph_clk_en);
    cfg(2, 32'h1);
    chk("gating", 32'h1, {31'h0, status.gating_en});
    @(posedge clk);
    sleep_req <= 1'b1;
    wait_cyc(1);
    chk("in_sleep", 32'h1, {31'h0, status.in_sleep});
    chk("clk_en_sleep", 32'h5, periph_clk_en);
    @(posedge clk);
    periph_wake <= 32'h2;
    wait_cyc(1);
    chk("wake_gated", 32'h0, {31'h0, wake_req});
    @(posedge clk);
    periph_wake <= 32'h4;
    wait_cyc(1);
    chk("wake", 32'h1, {31'h0, wake_req});
    @(posedge clk);
    periph_wake <= 32'h0;
    sleep_req   <= 1'b0;
    wait_cyc(1);
    chk("clk_en_wake", 32'h0010_000f, periph_clk_en);
    cfg(2, 32'h0);
    @(posedge clk);
    sleep_req <= 1'b1;
    wait_cyc(1);
    chk("clk_en_nogate", 32'h0010_000f, periph_clk_en);
    chk("sleep_en_kept", 32'h5, sleep_en_q);
    @(posedge clk);
    sleep_req <= 1'b0;
    wait_cyc(1);
    $display("test sleep done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A gated PWM time base holds its count through sleep, so the first tick
  // after wake comes only once the rest of the /4 period has run.
  task automatic test_retain();
    int   n;
    logic seen;
    cfg(3, 32'h2);
    cfg(2, 32'h1);
    n = 0;
    while (pwm_tick !== 1'b1 && n < 20) begin
      wait_cyc(1);
      n++;
    end
    chk("pwm_align", 32'h1, {31'h0, pwm_tick});
    @(posedge clk);
    sleep_req <= 1'b1;
    wait_cyc(1);
    chk("pwm_clk_off", 32'h0, {31'h0, periph_clk_en[20]});
    seen = 1'b0;
    repeat (8) begin
      wait_cyc(1);
      seen = seen | pwm_tick;
    end
    chk("pwm_gated", 32'h0, {31'h0, seen});
    @(posedge clk);
    sleep_req <= 1'b0;
    wait_cyc(2);
    chk("pwm_resume_early", 32'h0, {31'h0, pwm_tick});
    wait_cyc(1);
    chk("pwm_resume", 32'h1, {31'h0, pwm_tick});
    $display("test retain done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: inputs quiet at time zero, reset held four cycles.
  initial begin
    {rst, sleep_req, run_en_wr, sleep_en_wr, gating_wr, gating_data} = 6'h20;
    {run_en_data, sleep_en_data, periph_access, periph_wake} = '0;
    pwm_div_wr   = 1'b0;
    pwm_div_data = 3'h0;
    bad_count    = 0;
    cmp_count    = 0;
    cyc_cnt      = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(1);
    chk("status_rst", 32'h0, {27'h0, status});
    chk("clk_en_rst", 32'h0, periph_clk_en);
    test_ready();
    test_pwm();
    test_sleep();
    test_retain();
    test_done();
  end
endmodule
